// [hw/pic_ctrl.sv]
// Prioritised interrupt controller with Avalon-MM register access
// Function
// - Sample and decode requests every clock
// - Fastest response: detect one, call four
// - After return, one instruction before call
// - Worst case eighteen clocks via core timing
// - Equal or higher service blocks new request
// - Fixed vectors eight bytes apart by order
// - Hardware clears external and timer0/1 flags
// - Global enable gates every source
// - Primary enable bits map seven sources
// - Primary priority bit 7 reads one
// - Priority bit matches enable bit source
// - Extended enable bit 6 reads zero
// - Extended enable bit 1 reads zero
// - Extended enable bits map six sources
// - Timer2 and comparator enables gate both flags
// - Converter enables gate window and done flags
// - High preempts low, high never preempted
// - Same level: lower order granted first
// - Flag still set after return re-requests
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl
  import pic_pkg::*;
(
  input  wire logic               clock,                     // System clock
  input  wire logic               rst_n,                     // Async reset, low
  input  wire logic [ADDR_W-1:0]  address,                   // Avalon byte address
  input  wire logic               read,                      // Avalon read
  input  wire logic               write,                     // Avalon write
  input  wire logic [31:0]        writedata,                 // Avalon write data
  output logic      [31:0]        readdata,                  // Avalon read data
  output logic                    waitrequest,               // Avalon stall
  input  wire logic               instr_done,                // Core instruction boundary
  input  wire logic               ret_done,                  // Boundary is a return
  output logic                    irq_call,                  // Long call in progress
  output logic      [VEC_W-1:0]   irq_vector,                // Handler address
  output logic                    ext_line0_clear,           // Hardware flag clear
  output logic                    timer0_clear,              // Hardware flag clear
  output logic                    ext_line1_clear,           // Hardware flag clear
  output logic                    timer1_clear,              // Hardware flag clear
  input  wire logic               ext_line0_pending,         // Order 0 flag
  input  wire logic               timer0_overflow_flag,      // Order 1 flag
  input  wire logic               ext_line1_pending,         // Order 2 flag
  input  wire logic               timer1_overflow_flag,      // Order 3 flag
  input  wire logic               serial_port_rx_flag,       // Order 4 flag
  input  wire logic               serial_port_tx_flag,       // Order 4 flag
  input  wire logic               timer2_low_overflow_flag,  // Order 5 flag
  input  wire logic               timer2_high_overflow_flag, // Order 5 flag
  input  wire logic [3:0]         serial_periph_flags,       // Order 6 flags
  input  wire logic               serial_bus_flag,           // Order 7 flag
  input  wire logic               window_compare_flag,       // Order 9 flag
  input  wire logic               conversion_done_flag,      // Order 10 flag
  input  wire logic [3:0]         counter_array_flags,       // Order 11 flags
  input  wire logic               comparator_rise_flag,      // Order 12 flag
  input  wire logic               comparator_fall_flag,      // Order 12 flag
  input  wire logic               timer3_low_overflow_flag,  // Order 14 flag
  input  wire logic               timer3_high_overflow_flag  // Order 14 flag
);

  // ********************************************************
  // Registers and state
  // ********************************************************
  logic [7:0]        irq_enable_primary;     // Global plus seven enables
  logic [6:0]        irq_priority_primary;   // Stored priority bits 6..0
  logic [7:0]        irq_enable_extended;    // Extended enables
  logic [7:0]        irq_priority_extended;  // Extended priorities
  logic              bus_ack;                // Bus answer cycle
  logic [NSRC-1:0]   raw_req;                // Flags folded by source
  logic [NSRC-1:0]   src_en;                 // Enables by order
  logic [NSRC-1:0]   src_hi;                 // Priority by order
  logic [NSRC-1:0]   req_q;                  // Detected requests
  logic              global_irq_enable;      // Master enable
  logic              pick_found;             // Arbiter has a winner
  logic [ORD_W-1:0]  pick_order;             // Arbiter winner
  logic              pick_hi;                // Winner level
  logic              grant;                  // Start a long call
  pic_state_e        state;                  // Dispatcher state
  logic [1:0]        call_cnt;               // Long call cycle count
  logic              srv_lo;                 // Low-level handler running
  logic              srv_hi;                 // High-level handler running
  logic [ORD_W-1:0]  last_order;             // Last granted order
  logic [7:0]        reg_rd;                 // Selected read value

  // ********************************************************
  // Source folding and masking
  // ********************************************************
  assign global_irq_enable = irq_enable_primary[GLOBAL_BIT];

  // Several flags per source collapse into one request
  always_comb
  begin
    raw_req     = '0;
    raw_req[0]  = ext_line0_pending;
    raw_req[1]  = timer0_overflow_flag;
    raw_req[2]  = ext_line1_pending;
    raw_req[3]  = timer1_overflow_flag;
    raw_req[4]  = serial_port_rx_flag | serial_port_tx_flag;
    raw_req[5]  = timer2_low_overflow_flag | timer2_high_overflow_flag;
    raw_req[6]  = |serial_periph_flags;
    raw_req[7]  = serial_bus_flag;
    raw_req[9]  = window_compare_flag;
    raw_req[10] = conversion_done_flag;
    raw_req[11] = |counter_array_flags;
    raw_req[12] = comparator_rise_flag | comparator_fall_flag;
    raw_req[14] = timer3_low_overflow_flag | timer3_high_overflow_flag;
  end

  // Enable bits placed by order; orders 8 and 13 never request
  assign src_en = {irq_enable_extended[7], 1'b0,
                   irq_enable_extended[5:2], 1'b0,
                   irq_enable_extended[0],
                   irq_enable_primary[6:0]};

  // Priority bits follow the same placement as enables
  assign src_hi = {irq_priority_extended[7], 1'b0,
                   irq_priority_extended[5:2], 1'b0,
                   irq_priority_extended[0],
                   irq_priority_primary};

  // Detect stage: one clock to sample every request
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      req_q <= '0;
    else if (global_irq_enable)
      req_q <= raw_req & src_en;
    else
      req_q <= '0;
  end

  // ********************************************************
  // Arbitration and dispatch
  // ********************************************************
  pic_pick u_pick (
    .req      (req_q),
    .prio_hi  (src_hi),
    .found    (pick_found),
    .order    (pick_order),
    .level_hi (pick_hi)
  );

  // Take a call at a plain boundary, never at the return's own
  assign grant = (state == ST_IDLE) && instr_done && !ret_done
                 && pick_found && !srv_hi
                 && (!srv_lo || pick_hi);

  // Dispatcher: four call cycles after a grant
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_IDLE;
      call_cnt <= 2'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (grant)
          begin
            state    <= ST_CALL;
            call_cnt <= 2'h0;
          end
        end
        ST_CALL:
        begin
          // Last call cycle returns to idle
          if (call_cnt == 2'(CALL_CYC - 1))
            state <= ST_IDLE;
          call_cnt <= call_cnt + 2'h1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  assign irq_call = (state == ST_CALL);

  // Vector and order latched at the grant
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_vector <= VEC_RST;
      last_order <= '0;
    end
    else if (grant)
    begin
      irq_vector <= pic_vector(pick_order);
      last_order <= pick_order;
    end
  end

  // Hardware clear only for the four self-clearing sources
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_line0_clear <= 1'b0;
      timer0_clear    <= 1'b0;
      ext_line1_clear <= 1'b0;
      timer1_clear    <= 1'b0;
    end
    else
    begin
      ext_line0_clear <= grant && (pick_order == ORD_EXT0);
      timer0_clear    <= grant && (pick_order == ORD_TMR0);
      ext_line1_clear <= grant && (pick_order == ORD_EXT1);
      timer1_clear    <= grant && (pick_order == ORD_TMR1);
    end
  end

  // In-service levels: set on grant, innermost cleared on return
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srv_lo <= 1'b0;
      srv_hi <= 1'b0;
    end
    else if (grant)
    begin
      if (pick_hi)
        srv_hi <= 1'b1;
      else
        srv_lo <= 1'b1;
    end
    else if (ret_done && instr_done)
    begin
      if (srv_hi)
        srv_hi <= 1'b0;
      else
        srv_lo <= 1'b0;
    end
  end

  // ********************************************************
  // Avalon-MM slave: one wait cycle per access
  // ********************************************************
  assign waitrequest = (read || write) && !bus_ack;

  // Answer in the cycle after the request is seen
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bus_ack <= 1'b0;
    else
      bus_ack <= (read || write) && !bus_ack;
  end

  // Read decode; unmapped addresses read zero
  always_comb
  begin
    reg_rd = 8'h00;
    case (address)
      {IDX_EN_PRI,   2'b00}: reg_rd = irq_enable_primary;
      {IDX_PRIO_PRI, 2'b00}: reg_rd = PRIO_ONE | {1'b0, irq_priority_primary};
      {IDX_EIE,  2'b00}: reg_rd = irq_enable_extended & ~EXT_RSV;
      {IDX_EIP,  2'b00}: reg_rd = irq_priority_extended & ~EXT_RSV;
      {IDX_STAT, 2'b00}: reg_rd = {srv_hi, srv_lo, irq_call, 1'b0, last_order};
      default:           reg_rd = 8'h00;
    endcase
  end

  // Read data captured while waitrequest is high
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      readdata <= 32'h0000_0000;
    else if (read && !bus_ack)
      readdata <= {24'h00_0000, reg_rd};
  end

  // Writes land at the edge where waitrequest is low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_enable_primary    <= EN_PRI_RST;
      irq_priority_primary  <= PRIO_PRI_RST[6:0];
      irq_enable_extended   <= EIE_RST;
      irq_priority_extended <= EIP_RST;
    end
    else if (write && bus_ack)
    begin
      case (address)
        {IDX_EN_PRI,   2'b00}: irq_enable_primary    <= writedata[7:0];
        {IDX_PRIO_PRI, 2'b00}: irq_priority_primary  <= writedata[6:0];
        {IDX_EIE, 2'b00}: irq_enable_extended   <= writedata[7:0] & ~EXT_RSV;
        {IDX_EIP, 2'b00}: irq_priority_extended <= writedata[7:0] & ~EXT_RSV;
        default:          ;
      endcase
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [NSRC-1:0] past_raw;  // Helper: previous gated flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      past_raw <= '0;
    else
      past_raw <= global_irq_enable ? (raw_req & src_en) : '0;
  end

  chk_detect_one_clk: assert property (req_q == past_raw)
    else $error("request not detected one clock after flag");

  chk_call_four_clk: assert property (grant |=> irq_call [*4] ##1 !irq_call)
    else $error("long call not four clocks");

  chk_no_grant_ret: assert property (ret_done |-> !grant)
    else $error("call taken at return boundary");

  chk_vector_value: assert property (grant |=> irq_vector == pic_vector($past(pick_order)))
    else $error("vector does not match order");

  chk_hw_clear_ext0: assert property (grant && pick_order == ORD_EXT0 |=> ext_line0_clear)
    else $error("external line 0 flag not cleared");

  chk_no_sw_clear: assert property (grant && pick_order > ORD_TMR1
    |=> !(ext_line0_clear || timer0_clear || ext_line1_clear || timer1_clear))
    else $error("hardware clear for software-cleared source");

  chk_global_gate: assert property (!global_irq_enable |=> req_q == '0)
    else $error("request passed with global enable off");

  chk_prio_top_one: assert property (read && !bus_ack && address == {IDX_PRIO_PRI, 2'b00}
    |=> readdata[7])
    else $error("priority bit 7 read zero");

  chk_ext_reserved: assert property ((irq_enable_extended & EXT_RSV) == 8'h00)
    else $error("reserved enable bit set");

  chk_high_no_preempt: assert property (srv_hi |-> !grant)
    else $error("high-level handler preempted");

  chk_low_only_by_high: assert property (srv_lo && grant |-> pick_hi)
    else $error("low handler preempted by equal level");

  chk_same_level_order: assert property (grant |->
    ((req_q & (pick_hi ? src_hi : ~src_hi)) & ((15'h0001 << pick_order) - 15'h0001)) == '0)
    else $error("higher order granted before lower");

  cov_fast_call: cover property (raw_req[0] && src_en[0] && global_irq_enable ##1 grant);
  cov_preempt: cover property (srv_lo && grant && pick_hi);
  cov_ret_retake: cover property (ret_done && instr_done ##[1:20] grant);
  cov_bus_write: cover property (write && bus_ack);

endmodule : pic_ctrl
`default_nettype wire

// [hw/pic_pick.sv]
// Two-level fixed-order arbiter of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module pic_pick
  import pic_pkg::*;
(
  input  wire logic [NSRC-1:0]  req,       // Qualified requests by order
  input  wire logic [NSRC-1:0]  prio_hi,   // High level select by order
  output logic                  found,     // Some request present
  output logic [ORD_W-1:0]      order,     // Winning order
  output logic                  level_hi   // Winner is high level
);

  // ********************************************************
  // Lowest set order, with a found flag on top
  // ********************************************************
  function automatic logic [ORD_W:0] pic_first(input logic [NSRC-1:0] v);
    logic [ORD_W:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
        r = {1'b1, ORD_W'(i)};
    end
    return r;
  endfunction : pic_first

  logic [ORD_W:0] hi_pick;  // Best high-level request
  logic [ORD_W:0] lo_pick;  // Best low-level request

  // High level first, then fixed order within a level
  always_comb
  begin
    hi_pick = pic_first(req & prio_hi);
    lo_pick = pic_first(req & ~prio_hi);
    if (hi_pick[ORD_W])
    begin
      found    = 1'b1;
      order    = hi_pick[ORD_W-1:0];
      level_hi = 1'b1;
    end
    else
    begin
      found    = lo_pick[ORD_W];
      order    = lo_pick[ORD_W-1:0];
      level_hi = 1'b0;
    end
  end

endmodule : pic_pick
`default_nettype wire

// [hw/pic_pkg.sv]
// Constants, state codes and shared functions of the interrupt controller
package pic_pkg;

  // ********************************************************
  // Timing counts in system clocks
  // ********************************************************
  localparam int unsigned CLK_HZ       = 10_000_000;  // System clock rate
  localparam int unsigned DETECT_CYC   = 1;           // Request sampling stage
  localparam int unsigned CALL_CYC     = 4;           // Long call into the handler
  localparam int unsigned RET_CYC      = 5;           // Return instruction length
  localparam int unsigned DIV_CYC      = 8;           // Longest instruction length
  localparam int unsigned RESP_MIN_CYC = DETECT_CYC + CALL_CYC;
  localparam int unsigned RESP_MAX_CYC = DETECT_CYC + RET_CYC + DIV_CYC + CALL_CYC;

  // ********************************************************
  // Register indices; byte address is four times the index
  // ********************************************************
  localparam int unsigned ADDR_W    = 10;     // Avalon byte address width
  localparam logic [7:0]  IDX_EN_PRI   = 8'hA8;  // irq_enable_primary
  localparam logic [7:0]  IDX_PRIO_PRI = 8'hB8;  // irq_priority_primary
  localparam logic [7:0]  IDX_EIE   = 8'hE6;  // irq_enable_extended
  localparam logic [7:0]  IDX_EIP   = 8'hF6;  // irq_priority_extended
  localparam logic [7:0]  IDX_STAT  = 8'hF7;  // irq_status (read only)

  // ********************************************************
  // Reset values, fixed bits and field positions
  // ********************************************************
  localparam logic [7:0]  EN_PRI_RST   = 8'h00;  // Enables cleared
  localparam logic [7:0]  PRIO_PRI_RST = 8'h80;  // Top bit reads one
  localparam logic [7:0]  EIE_RST    = 8'h00;  // Extended enables cleared
  localparam logic [7:0]  EIP_RST    = 8'h00;  // Extended priorities low
  localparam logic [7:0]  PRIO_ONE   = 8'h80;  // Always-one bit
  localparam logic [7:0]  EXT_RSV    = 8'h42;  // Reserved bits 6 and 1
  localparam int unsigned GLOBAL_BIT = 7;      // global_irq_enable position

  // ********************************************************
  // Sources, orders and vectors
  // ********************************************************
  localparam int unsigned NSRC     = 15;        // Arbitration orders 0..14
  localparam int unsigned ORD_W    = 4;         // Order index width
  localparam int unsigned VEC_W    = 16;        // Vector address width
  localparam logic [15:0] VEC_BASE = 16'h0003;  // Vector of order 0
  localparam logic [15:0] VEC_RST  = 16'h0000;  // Vector after reset
  localparam logic [3:0]  ORD_EXT0 = 4'h0;      // External line 0
  localparam logic [3:0]  ORD_TMR0 = 4'h1;      // Timer 0 overflow
  localparam logic [3:0]  ORD_EXT1 = 4'h2;      // External line 1
  localparam logic [3:0]  ORD_TMR1 = 4'h3;      // Timer 1 overflow

  // Dispatcher states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } pic_state_e;

  // Vector address of an order, eight bytes apart
  function automatic logic [15:0] pic_vector(input logic [3:0] ord);
    return VEC_BASE + {9'h000, ord, 3'h0};
  endfunction : pic_vector

endpackage : pic_pkg

// [tb/pic_core_model.sv]
// Core and peripheral flag model facing the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module pic_core_model
(
  input  wire logic        clock,       // System clock
  input  wire logic        rst_n,       // Async reset, low
  input  wire logic        irq_call,    // Long call in progress
  input  wire logic [3:0]  hw_clr,      // Hardware clears, orders 3..0
  input  wire logic        ret_req,     // Next boundary is a return
  input  wire logic [22:0] set_mask,    // Flags raised by events
  input  wire logic [22:0] sw_clr,      // Flags cleared by software
  output logic             instr_done,  // Instruction boundary
  output logic             ret_done,    // Boundary is a return
  output logic [22:0]      flags        // Pending flags
);
  // One-cycle instructions; no boundary while the call runs
  assign instr_done = rst_n & !irq_call;
  assign ret_done   = instr_done & ret_req;
  // Flags set by events, cleared by software or hardware pulse
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      flags <= '0;
    else
      flags <= (flags | set_mask) & ~sw_clr & ~{19'h0, hw_clr};
endmodule : pic_core_model
`default_nettype wire

// [tb/prioritised_interrupt_controller_tb_top.sv]
// Self-checking bench of the prioritised interrupt controller
`timescale 1ns/1ns
`default_nettype none
`define chk_eq(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module prioritised_interrupt_controller_tb_top;
  import pic_pkg::*;
  logic              clock = 0, rst_n = 0, read = 0, write = 0, ret_req = 0;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0]       writedata = '0, readdata;
  logic              waitrequest, instr_done, ret_done, irq_call;
  logic [VEC_W-1:0]  irq_vector;
  logic [3:0]        hw_clr;
  logic [22:0]       set_mask = '0, sw_clr = '0, flags;
  logic [7:0]        q;
  int                err_total = 0, n_tests = 0, cyc = 0, n;
  int                fi[14] = '{0, 1, 2, 3, 5, 7, 6, 10, 12, 13, 14, 17, 20, 22};
  int                od[14] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 9, 10, 11, 12, 14};
  always #50 clock = ~clock;
  pic_ctrl DUT (.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .instr_done(instr_done), .ret_done(ret_done), .irq_call(irq_call), .irq_vector(irq_vector),
    .ext_line0_clear(hw_clr[0]), .timer0_clear(hw_clr[1]), .ext_line1_clear(hw_clr[2]),
    .timer1_clear(hw_clr[3]), .ext_line0_pending(flags[0]), .timer0_overflow_flag(flags[1]),
    .ext_line1_pending(flags[2]), .timer1_overflow_flag(flags[3]),
    .serial_port_rx_flag(flags[4]), .serial_port_tx_flag(flags[5]),
    .timer2_low_overflow_flag(flags[6]), .timer2_high_overflow_flag(flags[7]),
    .serial_periph_flags(flags[11:8]), .serial_bus_flag(flags[12]),
    .window_compare_flag(flags[13]), .conversion_done_flag(flags[14]),
    .counter_array_flags(flags[18:15]), .comparator_rise_flag(flags[19]),
    .comparator_fall_flag(flags[20]), .timer3_low_overflow_flag(flags[21]),
    .timer3_high_overflow_flag(flags[22]));
  pic_core_model PARTNER (.clock(clock), .rst_n(rst_n), .irq_call(irq_call), .hw_clr(hw_clr),
    .ret_req(ret_req), .set_mask(set_mask), .sw_clr(sw_clr), .instr_done(instr_done),
    .ret_done(ret_done), .flags(flags));
  // One Avalon access; holds until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock);
    address <= {idx, 2'b00};
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  // Raise (s=1) or software-clear (s=0) flags for one cycle
  task automatic flg(input logic s, input logic [22:0] m);
    @(posedge clock);
    if (s) set_mask <= m;
    else sw_clr <= m;
    @(posedge clock);
    set_mask <= '0;
    sw_clr <= '0;
  endtask : flg
  // Waits for a long call; checks vector and call length
  task automatic take(input logic [15:0] v);
    int k;
    k = 0;
    n = 0;
    do begin @(posedge clock); n++; end while (irq_call !== 1'b1);
    `chk_eq(irq_vector, v)
    while (irq_call === 1'b1) begin @(posedge clock); k++; end
    `chk_eq(k, CALL_CYC)
  endtask : take
  // Return from the running handler
  task automatic ret;
    @(posedge clock);
    ret_req <= 1'b1;
    @(posedge clock);
    ret_req <= 1'b0;
  endtask : ret
  // Verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 6000) begin err_total++; conclude(); end
  end
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    acc(0, IDX_EN_PRI, 0); `chk_eq(q, 8'h00)
    acc(0, IDX_PRIO_PRI, 0); `chk_eq(q, 8'h80)
    acc(0, IDX_EIE, 0); `chk_eq(q, 8'h00)
    acc(1, IDX_PRIO_PRI, 8'h00); acc(0, IDX_PRIO_PRI, 0); `chk_eq(q, 8'h80)
    acc(1, IDX_EIE, 8'hBD); acc(0, IDX_EIE, 0); `chk_eq(q, 8'hBD)
    acc(1, 8'h10, 8'hFF); acc(0, 8'h10, 0); `chk_eq(q, 8'h00)
    acc(1, IDX_EN_PRI, 8'h7F); acc(0, IDX_EN_PRI, 0); `chk_eq(q, 8'h7F)
    $display("test registers done");
    acc(1, IDX_EN_PRI, 8'h01);
    flg(1, 23'h1);
    n = 0;
    repeat (8) @(posedge clock) if (irq_call !== 1'b0) n++;
    `chk_eq(n, 0)
    flg(0, 23'h1);
    $display("test global enable done");
    for (int i = 0; i < 14; i++)
    begin
      acc(1, IDX_EN_PRI, od[i] < 7 ? 8'h80 | 8'(1 << od[i]) : 8'h80);
      acc(1, IDX_EIE, od[i] < 7 ? 8'h00 : 8'(1 << (od[i] - 7)));
      flg(1, 23'h1 << fi[i]);
      take(16'h0003 + 16'(od[i] * 8));
      `chk_eq(n, 3)
      `chk_eq(flags[fi[i]], (od[i] > 3) ? 1'b1 : 1'b0)
      flg(0, 23'h1 << fi[i]);
      ret;
    end
    $display("test sources done");
    acc(1, IDX_EN_PRI, 8'h8A);
    acc(1, IDX_PRIO_PRI, 8'h08); acc(0, IDX_PRIO_PRI, 0); `chk_eq(q, 8'h88)
    flg(1, 23'h0A); take(16'h001B); ret; take(16'h000B); ret;
    flg(1, 23'h02); take(16'h000B); flg(1, 23'h08); take(16'h001B); ret; ret;
    acc(1, IDX_PRIO_PRI, 8'h00);
    flg(1, 23'h0A); take(16'h000B); ret; take(16'h001B); ret;
    $display("test priority done");
    acc(1, IDX_EN_PRI, 8'h80);
    acc(1, IDX_EIE, 8'h01);
    flg(1, 23'h1000); take(16'h003B); ret;
    take(16'h003B); `chk_eq(n, 2)
    flg(0, 23'h1000);
    ret;
    $display("test re-request done");
    conclude();
  end
endmodule : prioritised_interrupt_controller_tb_top
`default_nettype wire
